// [rtl/pac_accum.sv]
// pulse accumulate, chop and sample averaging stage with axi4-lite registers
// assumes pulse results arrive on clk_sys, one pulse per cycle at most
`timescale 1ns/1ns
`include "pac_map.svh"
module pac_accum #(
    parameter int ADC_W = 14,
    parameter int OUT_W = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // axi4-lite write channels
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // digitized pulse results from the adc
    input wire logic pulse_valid,
    input wire logic pulse_slot,
    input wire logic signed [ADC_W-1:0] pulse_data,
    // integrator polarity for the next pulse of each slot
    output logic integ_reverse_a,
    output logic integ_reverse_b,
    // combined output value
    output logic out_valid,
    output logic out_slot,
    output logic [OUT_W-1:0] out_data
);

    // accumulator must hold 255 pulses times 128 samples
    if (OUT_W < ADC_W + 15 || OUT_W > 32) begin : g_bad_width
        $error("pac_accum: OUT_W must lie between ADC_W+15 and 32");
    end

    // whole module state
    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_idx;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [15:0] freq;
        logic [15:0] avg;
        logic [15:0] patt_a;
        logic [15:0] patt_b;
        logic [15:0] setup_a;
        logic [15:0] setup_b;
        logic [15:0] math;
        logic [3:0][15:0] off_a;
        logic [3:0][15:0] off_b;
        logic [1:0][7:0] pcnt;
        logic [1:0][6:0] scnt;
        logic [1:0][OUT_W-1:0] acc;
        logic [1:0][OUT_W-1:0] result;
        logic out_valid;
        logic out_slot;
        logic [OUT_W-1:0] out_data;
    } pac_state_s;

    pac_state_s q;
    pac_state_s d;

    // byte-lane merge into a 16-bit register, upper lanes unused
    function automatic logic [15:0] pac_merge(input logic [15:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0] st);
        pac_merge = {st[1] ? dat[15:8] : old[15:8], st[0] ? dat[7:0] : old[7:0]};
    endfunction

    // next state: bus slave and pulse datapath
    always_comb begin
        logic [31:0] rd;
        logic rd_err;
        logic wr_err;
        logic [7:0] ridx;
        logic s;
        logic [1:0] pidx;
        logic [1:0] pair;
        logic sub;
        logic [7:0] pc;
        logic [2:0] avg_n;
        logic [7:0] samples;
        logic [OUT_W-1:0] term;
        logic [OUT_W-1:0] acc_n;
        rd = 32'h0000_0000;
        rd_err = 1'b0;
        wr_err = 1'b0;
        ridx = s_axi_araddr[9:2];
        s = pulse_slot;
        pidx = q.pcnt[s][1:0];
        pair = 2'h0;
        sub = 1'b0;
        pc = 8'h00;
        avg_n = 3'h0;
        samples = 8'h00;
        term = OUT_W'(pulse_data);
        acc_n = q.acc[s];
        d = q;
        d.out_valid = 1'b0;
        // responses retire before new ones are raised
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        // address and data are taken in either order
        if (s_axi_awvalid && !q.aw_full) begin
            d.aw_full = 1'b1;
            d.aw_idx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && !q.w_full) begin
            d.w_full = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        // write once both halves are held and the last response is gone
        if (d.aw_full && d.w_full && !q.bvalid) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            unique case (d.aw_idx) inside
                `PAC_IDX_SAMPLE_FREQ: d.freq = pac_merge(q.freq, d.w_data, d.w_strb);
                `PAC_IDX_AVERAGING: d.avg = pac_merge(q.avg, d.w_data, d.w_strb);
                `PAC_IDX_PATTERN_A: d.patt_a = pac_merge(q.patt_a, d.w_data, d.w_strb);
                `PAC_IDX_PATTERN_B: d.patt_b = pac_merge(q.patt_b, d.w_data, d.w_strb);
                `PAC_IDX_SETUP_A: d.setup_a = pac_merge(q.setup_a, d.w_data, d.w_strb);
                `PAC_IDX_SETUP_B: d.setup_b = pac_merge(q.setup_b, d.w_data, d.w_strb);
                `PAC_IDX_MATH: d.math = pac_merge(q.math, d.w_data, d.w_strb);
                [`PAC_IDX_OFFSET_A:`PAC_IDX_OFFSET_A_LAST]: begin
                    d.off_a[2'(d.aw_idx - `PAC_IDX_OFFSET_A)] =
                        pac_merge(q.off_a[2'(d.aw_idx - `PAC_IDX_OFFSET_A)], d.w_data, d.w_strb);
                end
                [`PAC_IDX_OFFSET_B:`PAC_IDX_OFFSET_B_LAST]: begin
                    d.off_b[2'(d.aw_idx - `PAC_IDX_OFFSET_B)] =
                        pac_merge(q.off_b[2'(d.aw_idx - `PAC_IDX_OFFSET_B)], d.w_data, d.w_strb);
                end
                // status and results are read-only, writes dropped quietly
                `PAC_IDX_STATUS, `PAC_IDX_RESULT_A, `PAC_IDX_RESULT_B: wr_err = 1'b0;
                default: wr_err = 1'b1;
            endcase
            d.bresp = wr_err ? pac_pkg::PAC_RESP_SLVERR : pac_pkg::PAC_RESP_OKAY;
        end
        // read mux, answered one cycle after the address is taken
        unique case (ridx) inside
            `PAC_IDX_SAMPLE_FREQ: rd = {16'h0000, q.freq};
            `PAC_IDX_AVERAGING: rd = {16'h0000, q.avg};
            `PAC_IDX_PATTERN_A: rd = {16'h0000, q.patt_a};
            `PAC_IDX_PATTERN_B: rd = {16'h0000, q.patt_b};
            `PAC_IDX_SETUP_A: rd = {16'h0000, q.setup_a};
            `PAC_IDX_SETUP_B: rd = {16'h0000, q.setup_b};
            `PAC_IDX_MATH: rd = {16'h0000, q.math};
            [`PAC_IDX_OFFSET_A:`PAC_IDX_OFFSET_A_LAST]:
                rd = {16'h0000, q.off_a[2'(ridx - `PAC_IDX_OFFSET_A)]};
            [`PAC_IDX_OFFSET_B:`PAC_IDX_OFFSET_B_LAST]:
                rd = {16'h0000, q.off_b[2'(ridx - `PAC_IDX_OFFSET_B)]};
            `PAC_IDX_STATUS: rd = {1'b0, q.scnt[1], 1'b0, q.scnt[0], q.pcnt[1], q.pcnt[0]};
            `PAC_IDX_RESULT_A: rd = 32'($signed(q.result[0]));
            `PAC_IDX_RESULT_B: rd = 32'($signed(q.result[1]));
            default: rd_err = 1'b1;
        endcase
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rdata = rd;
            d.rresp = rd_err ? pac_pkg::PAC_RESP_SLVERR : pac_pkg::PAC_RESP_OKAY;
        end
        // per-slot field selection
        if (s == pac_pkg::PAC_SLOT_A) begin
            pair = pidx[1] ? q.math[`PAC_MATH34_A_LSB +: 2] : q.math[`PAC_MATH12_A_LSB +: 2];
            pc = q.setup_a[`PAC_PCNT_LSB +: 8];
            avg_n = q.avg[`PAC_AVG_A_LSB +: 3];
        end else begin
            pair = pidx[1] ? q.math[`PAC_MATH34_B_LSB +: 2] : q.math[`PAC_MATH12_B_LSB +: 2];
            pc = q.setup_b[`PAC_PCNT_LSB +: 8];
            avg_n = q.avg[`PAC_AVG_B_LSB +: 3];
        end
        // a zero pulse count behaves as one pulse per sample
        if (pc == 8'h00) begin
            pc = 8'h01;
        end
        samples = 8'h01 << avg_n;
        // high bit rules the earlier pulse of the pair, low bit the later
        sub = pidx[0] ? pair[0] : pair[1];
        // subtract pulses whose pair-code bit is set, add the rest; zero fields give a plain sum
        acc_n = sub ? q.acc[s] - term : q.acc[s] + term;
        if (pulse_valid) begin
            d.acc[s] = acc_n;
            if ({1'b0, q.pcnt[s]} + 9'h001 >= {1'b0, pc}) begin
                // sample ends: pattern index restarts with the next sample
                d.pcnt[s] = 8'h00;
                if ({1'b0, q.scnt[s]} + 8'h01 >= samples) begin
                    // group complete: emit and clear for the next group
                    d.scnt[s] = 7'h00;
                    d.acc[s] = '0;
                    d.result[s] = acc_n;
                    d.out_valid = 1'b1;
                    d.out_slot = s;
                    d.out_data = acc_n;
                end else begin
                    d.scnt[s] = q.scnt[s] + 7'h01;
                end
            end else begin
                d.pcnt[s] = q.pcnt[s] + 8'h01;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.setup_a <= `PAC_RST_SETUP;
            q.setup_b <= `PAC_RST_SETUP;
        end else begin
            q <= d;
        end
    end

    // outputs: handshakes from state, polarity from pattern and pulse index
    assign s_axi_awready = !q.aw_full;
    assign s_axi_wready = !q.w_full;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign integ_reverse_a = q.patt_a[q.pcnt[0][1:0]];
    assign integ_reverse_b = q.patt_b[q.pcnt[1][1:0]];
    assign out_valid = q.out_valid;
    assign out_slot = q.out_slot;
    assign out_data = q.out_data;

    // ---- checks ----
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // helper terms for slot a, derived apart from the datapath
    logic [7:0] hp_pc_a;
    logic [7:0] hp_samp_a;
    logic hp_last_a;
    logic hp_emit_a;
    logic hp_sub_a;
    logic [15:0] hp_tot_q;
    assign hp_pc_a = (q.setup_a[15:8] == 8'h00) ? 8'h01 : q.setup_a[15:8];
    assign hp_samp_a = 8'h01 << q.avg[6:4];
    assign hp_last_a = pulse_valid && !pulse_slot && (q.pcnt[0] == hp_pc_a - 8'h01);
    assign hp_emit_a = hp_last_a && ({1'b0, q.scnt[0]} == hp_samp_a - 8'h01);
    always_comb begin
        unique case (q.pcnt[0][1:0])
            2'h0: hp_sub_a = q.math[2];
            2'h1: hp_sub_a = q.math[1];
            2'h2: hp_sub_a = q.math[9];
            2'h3: hp_sub_a = q.math[8];
        endcase
    end
    // pulses of slot a since its last output
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hp_tot_q <= 16'h0000;
        end else if (pulse_valid && !pulse_slot) begin
            hp_tot_q <= hp_emit_a ? 16'h0000 : hp_tot_q + 16'h0001;
        end
    end

    sequence s_mid_pulse_a;
        pulse_valid && !pulse_slot && !hp_emit_a;
    endsequence
    sequence s_group_end_a;
        hp_emit_a;
    endsequence

    a_out_follows: assert property (out_valid |-> $past(pulse_valid) &&
        ($past(pulse_slot) == out_slot))
        else $error("output without a closing pulse");
    a_pulse_wrap: assert property (hp_last_a |=> q.pcnt[0] == 8'h00)
        else $error("pulse index did not restart after last pulse");
    a_sample_group: assert property (s_group_end_a |=> out_valid && !out_slot &&
        out_data == q.result[0])
        else $error("group end gave no slot a output");
    a_total_pulses: assert property (s_group_end_a ##0 ($stable(q.setup_a) &&
        $stable(q.avg)) |-> ({8'h00, hp_pc_a} * {8'h00, hp_samp_a} == hp_tot_q + 16'h0001))
        else $error("pulse total per output is wrong");
    a_pattern_reuse: assert property (s_mid_pulse_a ##0 (q.pcnt[0] == 8'h03)
        |=> integ_reverse_a == q.patt_a[0])
        else $error("pattern not reused after fourth pulse");
    a_chop_sign: assert property (s_mid_pulse_a |=> q.acc[0] ==
        ($past(hp_sub_a) ? $past(q.acc[0]) - OUT_W'($past(pulse_data))
                         : $past(q.acc[0]) + OUT_W'($past(pulse_data))))
        else $error("pulse sign does not follow math field");
    a_plain_sum: assert property (s_mid_pulse_a ##0 (q.patt_a[3:0] == 4'h0) &&
        (q.math[2:1] == 2'h0) && (q.math[9:8] == 2'h0)
        |=> q.acc[0] == $past(q.acc[0]) + OUT_W'($past(pulse_data)))
        else $error("non-chopped slot did not add");
    a_acc_clear: assert property (s_group_end_a |=> q.acc[0] == '0 && q.scnt[0] == 7'h00)
        else $error("accumulator not cleared at group end");

endmodule

// [rtl/pac_map.svh]
// register indices, field positions and reset values of the pulse combiner
// assumes byte address = 4 * index on a 32-bit AXI4-Lite slave
// Summary of operation
// - pulses per sample from setup bits 15:8
// - averaging fields pick samples combined per slot
// - one output per group of combined samples
// - output pulses equal pulses times samples
// - pulses with pair code bit set subtracted, others added
// - four-bit polarity pattern repeats every four pulses
// - pair math fields per slot, pulses 1-2, 3-4
// - code 01 adds earlier, subtracts later pulse
// - pattern bit 0 is pulse 1; 1 reverses
// - 00 add, 01 add-sub, 10 sub-add, 11 sub
`ifndef PAC_MAP_SVH
`define PAC_MAP_SVH

// register indices
`define PAC_IDX_SAMPLE_FREQ 8'h12
`define PAC_IDX_AVERAGING 8'h15
`define PAC_IDX_PATTERN_A 8'h17
`define PAC_IDX_OFFSET_A 8'h18
`define PAC_IDX_OFFSET_A_LAST 8'h1B
`define PAC_IDX_PATTERN_B 8'h1D
`define PAC_IDX_OFFSET_B 8'h1E
`define PAC_IDX_OFFSET_B_LAST 8'h21
`define PAC_IDX_SETUP_A 8'h31
`define PAC_IDX_SETUP_B 8'h36
`define PAC_IDX_MATH 8'h58
`define PAC_IDX_STATUS 8'h60
`define PAC_IDX_RESULT_A 8'h61
`define PAC_IDX_RESULT_B 8'h62

// field positions
`define PAC_PCNT_LSB 8
`define PAC_AVG_A_LSB 4
`define PAC_AVG_B_LSB 8
`define PAC_MATH12_A_LSB 1
`define PAC_MATH12_B_LSB 5
`define PAC_MATH34_A_LSB 8
`define PAC_MATH34_B_LSB 10

// reset values
`define PAC_RST_REG 16'h0000
`define PAC_RST_SETUP 16'h0100

`endif

// [rtl/pac_pkg.sv]
// shared types of the pulse combiner
// assumes the map header carries all register numbers and field positions
package pac_pkg;
    // time slot selector
    typedef enum logic {PAC_SLOT_A, PAC_SLOT_B} pac_slot_e;
    // axi response code
    typedef logic [1:0] pac_resp_t;
    localparam pac_resp_t PAC_RESP_OKAY = 2'h0;
    localparam pac_resp_t PAC_RESP_SLVERR = 2'h2;
endpackage

// [verif/pac_accum_test.sv]
// self-checking bench for the pulse accumulate, chop and averaging stage
// assumes pac_accum at default widths and the register map header on the include path
`timescale 1ns/1ns
`include "pac_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module pac_accum_test;
    // clock and reset
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    // register bus
    logic [9:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    // pulse stream and outputs
    logic pulse_valid, pulse_slot, integ_reverse_a, integ_reverse_b, out_valid, out_slot;
    logic signed [13:0] pulse_data;
    logic [31:0] out_data;
    // bookkeeping
    int n_mismatch = 0;
    int check_count = 0;
    int n_out = 0;
    int k;
    logic signed [31:0] last_exp;

    always #4 clk_sys = ~clk_sys;

    pac_accum u_pac_accum (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .pulse_valid(pulse_valid), .pulse_slot(pulse_slot), .pulse_data(pulse_data),
        .integ_reverse_a(integ_reverse_a), .integ_reverse_b(integ_reverse_b),
        .out_valid(out_valid), .out_slot(out_slot), .out_data(out_data)
    );

    // count output strobes; non-blocking so readers at the same edge see a stable count
    always @(posedge clk_sys) begin
        if (out_valid === 1'b1) begin
            n_out <= n_out + 1;
        end
    end

    // verdict and end of run
    task automatic finish_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // a wait that ran out is a mismatch
    task automatic fail_wait();
        n_mismatch++;
        finish_test();
    endtask

    // one write, address and data offered together
    task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) fail_wait();
        `CHK("bresp", er, s_axi_bresp)
    endtask

    // one read, data and response compared
    task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50) fail_wait();
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask

    // back-to-back pulses of one output group; sign per pair code, polarity per pattern
    task automatic grp(input logic s, input int pc, input int ns, input logic [3:0] pat,
                       input logic [1:0] m12, input logic [1:0] m34, input int base);
        int i, p, n0, n;
        logic [1:0] c;
        logic signed [13:0] d;
        logic signed [31:0] e;
        e = '0;
        n0 = n_out;
        for (i = 0; i < pc * ns; i++) begin
            p = i % pc;
            c = p[1] ? m34 : m12;
            d = 14'(base + i * 53);
            e = (p[0] ? c[0] : c[1]) ? e - 32'(d) : e + 32'(d);
            // the previous pulse is taken at this edge, so the index now points at pulse i
            @(posedge clk_sys);
            pulse_valid <= 1'b1;
            pulse_slot <= s;
            pulse_data <= d;
            @(negedge clk_sys);
            `CHK("reverse", pat[p % 4], s ? integ_reverse_b : integ_reverse_a)
            `CHK("early out", n0, n_out)
        end
        @(posedge clk_sys);
        pulse_valid <= 1'b0;
        for (n = 0; n < 10 && n_out == n0; n++) @(posedge clk_sys);
        if (n == 10) fail_wait();
        `CHK("out count", n0 + 1, n_out)
        `CHK("out data", e, out_data)
        `CHK("out slot", s, out_slot)
        last_exp = e;
    endtask

    // main sequence
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {pulse_valid, pulse_slot, pulse_data} = '0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset values and an unmapped index
        rd(`PAC_IDX_SETUP_A, 32'h00000100, pac_pkg::PAC_RESP_OKAY);
        rd(`PAC_IDX_SETUP_B, 32'h00000100, pac_pkg::PAC_RESP_OKAY);
        rd(`PAC_IDX_AVERAGING, 32'h00000000, pac_pkg::PAC_RESP_OKAY);
        rd(`PAC_IDX_MATH, 32'h00000000, pac_pkg::PAC_RESP_OKAY);
        rd(8'h40, 32'h00000000, pac_pkg::PAC_RESP_SLVERR);
        wr(8'h40, 16'h1234, pac_pkg::PAC_RESP_SLVERR);
        // software side: rate raised by the averaging factor, offsets zeroed for chop
        wr(`PAC_IDX_SAMPLE_FREQ, 16'h0190, pac_pkg::PAC_RESP_OKAY);
        rd(`PAC_IDX_SAMPLE_FREQ, 32'h00000190, pac_pkg::PAC_RESP_OKAY);
        // upper byte lane only: the low byte keeps its old value
        s_axi_wstrb <= 4'h2;
        wr(`PAC_IDX_SAMPLE_FREQ, 16'hABCD, pac_pkg::PAC_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(`PAC_IDX_SAMPLE_FREQ, 32'h0000AB90, pac_pkg::PAC_RESP_OKAY);
        // every offset of both slots held apart, then zeroed for chop
        for (k = 0; k < 4; k++) begin
            wr(8'(`PAC_IDX_OFFSET_A + k), 16'(16'h0A00 + k), pac_pkg::PAC_RESP_OKAY);
            wr(8'(`PAC_IDX_OFFSET_B + k), 16'(16'h0B00 + k), pac_pkg::PAC_RESP_OKAY);
            rd(8'(`PAC_IDX_OFFSET_A + k), 32'(16'h0A00 + k), pac_pkg::PAC_RESP_OKAY);
            rd(8'(`PAC_IDX_OFFSET_B + k), 32'(16'h0B00 + k), pac_pkg::PAC_RESP_OKAY);
            wr(8'(`PAC_IDX_OFFSET_A + k), 16'h0000, pac_pkg::PAC_RESP_OKAY);
            wr(8'(`PAC_IDX_OFFSET_B + k), 16'h0000, pac_pkg::PAC_RESP_OKAY);
            rd(8'(`PAC_IDX_OFFSET_B + k), 32'h00000000, pac_pkg::PAC_RESP_OKAY);
        end
        // plain sum of three pulses, odd count since chop is off
        wr(`PAC_IDX_SETUP_A, 16'h0300, pac_pkg::PAC_RESP_OKAY);
        grp(1'b0, 3, 1, 4'h0, 2'h0, 2'h0, -700);
        // chop over eight pulses, pattern repeating every four
        wr(`PAC_IDX_PATTERN_A, 16'h000A, pac_pkg::PAC_RESP_OKAY);
        rd(`PAC_IDX_PATTERN_A, 32'h0000000A, pac_pkg::PAC_RESP_OKAY);
        wr(`PAC_IDX_MATH, 16'h0102, pac_pkg::PAC_RESP_OKAY);
        wr(`PAC_IDX_SETUP_A, 16'h0800, pac_pkg::PAC_RESP_OKAY);
        grp(1'b0, 8, 1, 4'hA, 2'h1, 2'h1, 300);
        // result register is read-only
        wr(`PAC_IDX_RESULT_A, 16'h5555, pac_pkg::PAC_RESP_OKAY);
        rd(`PAC_IDX_RESULT_A, last_exp, pac_pkg::PAC_RESP_OKAY);
        // every pair code on both pairs
        wr(`PAC_IDX_PATTERN_A, 16'h0000, pac_pkg::PAC_RESP_OKAY);
        wr(`PAC_IDX_SETUP_A, 16'h0400, pac_pkg::PAC_RESP_OKAY);
        for (k = 0; k < 4; k++) begin
            wr(`PAC_IDX_MATH, 16'((k << 1) | (k << 8)), pac_pkg::PAC_RESP_OKAY);
            grp(1'b0, 4, 1, 4'h0, 2'(k), 2'(k), 200 - 150 * k);
        end
        // two samples of two pulses per output, twice to see the clear
        wr(`PAC_IDX_AVERAGING, 16'h0010, pac_pkg::PAC_RESP_OKAY);
        wr(`PAC_IDX_PATTERN_A, 16'h000E, pac_pkg::PAC_RESP_OKAY);
        wr(`PAC_IDX_MATH, 16'h0002, pac_pkg::PAC_RESP_OKAY);
        wr(`PAC_IDX_SETUP_A, 16'h0200, pac_pkg::PAC_RESP_OKAY);
        grp(1'b0, 2, 2, 4'hE, 2'h1, 2'h0, 100);
        grp(1'b0, 2, 2, 4'hE, 2'h1, 2'h0, -400);
        // slot b fields, two samples of four pulses
        wr(`PAC_IDX_AVERAGING, 16'h0100, pac_pkg::PAC_RESP_OKAY);
        wr(`PAC_IDX_PATTERN_B, 16'h0003, pac_pkg::PAC_RESP_OKAY);
        wr(`PAC_IDX_MATH, 16'h0C40, pac_pkg::PAC_RESP_OKAY);
        wr(`PAC_IDX_SETUP_B, 16'h0400, pac_pkg::PAC_RESP_OKAY);
        grp(1'b1, 4, 2, 4'h3, 2'h2, 2'h3, 900);
        rd(`PAC_IDX_RESULT_B, last_exp, pac_pkg::PAC_RESP_OKAY);
        // every group closed, so both pulse and sample counters are back at zero
        rd(`PAC_IDX_STATUS, 32'h00000000, pac_pkg::PAC_RESP_OKAY);
        finish_test();
    end
endmodule
